// [rtl/tvi_picker.sv]
// fixed polling-order picker: lowest index wins
`timescale 1ns/100ps
module tvi_picker
    import tvi_pkg::*;
(
    tvi_req_if.picker bus
);
    always_comb begin
        bus.valid = 1'b0;
        bus.idx = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (bus.req[i]) begin
                bus.valid = 1'b1;
                bus.idx = 3'(i);
            end
        end
    end
endmodule // tvi_picker

// [rtl/tvi_pkg.sv]
// constants for the two-level vectored interrupt unit
package tvi_pkg;
    // ======================================================
    // source count and indices in polling order
    localparam int NSRC = 6;
    localparam logic [2:0] SRC_EXT0 = 3'h0;
    localparam logic [2:0] SRC_TMR0 = 3'h1;
    localparam logic [2:0] SRC_EXT1 = 3'h2;
    localparam logic [2:0] SRC_TMR1 = 3'h3;
    localparam logic [2:0] SRC_UART = 3'h4;
    localparam logic [2:0] SRC_TMR2 = 3'h5;
    // ======================================================
    // special register addresses
    localparam logic [7:0] ADDR_TMR01_CTRL = 8'h88;
    localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
    localparam logic [7:0] ADDR_IRQ_LEVEL = 8'hB8;
    localparam logic [7:0] ADDR_TMR2_CTRL = 8'hC8;
    // ======================================================
    // flag bit positions
    localparam int BIT_EXT0_PEND = 1;
    localparam int BIT_EXT1_PEND = 3;
    localparam int BIT_TMR0_OVF = 5;
    localparam int BIT_TMR1_OVF = 7;
    localparam int BIT_UART_RX = 0;
    localparam int BIT_UART_TX = 1;
    localparam int BIT_TMR2_EDGE = 6;
    localparam int BIT_TMR2_OVF = 7;
    localparam int BIT_GLOBAL_GATE = 7;
    // ======================================================
    // reset and read-back values
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
    localparam logic [5:0] IRQ_LEVEL_RST = 6'h00;
    localparam logic [7:0] IRQ_LEVEL_FIXED = 8'h80;
    // ======================================================
    // vector layout: base plus eight bytes per source
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_SHIFT = 3;
endpackage

// [rtl/tvi_req_if.sv]
// request vector and winner between top and priority picker
`timescale 1ns/100ps
interface tvi_req_if;
    import tvi_pkg::*;
    logic [NSRC-1:0] req;
    logic valid;
    logic [2:0] idx;
    modport picker (input req, output valid, output idx);
    modport user (output req, input valid, input idx);
endinterface

// [rtl/tvi_top.sv]
// two-level vectored interrupt unit: flags, enables, levels, arbitration
// Summary of operation
// - six sources, two priority levels, one vector per source
// - sources: ext0, timer0, ext1, timer1, serial port, timer2 overflow/edge
// - events set sticky flags; only software clears them
// - ext0/ext1 flags at control bits 1/3, timer0/1 at bits 5/7
// - serial request is OR of transmit-done bit 1 and receive-done bit 0
// - timer2 overflow and edge flags share one request and vector 002BH
// - vectors fixed: 0003H, 000BH, 0013H, 001BH, 0023H, 002BH
// - enable register at A8; a source needs its own enable bit
// - enable bit 7 gates all interrupts globally
// - enable bits 0..5 per source in order; bit 6 absent
// - enable register resets to zero
// - level register at B8, one bit per source, 1 means high
// - high-level request preempts a low-level service routine
// - during high-level service nothing else is accepted
// - simultaneous requests: high level served first
// - same level: fixed polling order ext0 first, timer2 last
// - level bits 0..5 per source in order; bit 7 reads one
`timescale 1ns/100ps
module tvi_top
    import tvi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    // special register port from the core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // event pulses from the peripherals
    input wire logic ext0_evt,
    input wire logic tmr0_ovf_evt,
    input wire logic ext1_evt,
    input wire logic tmr1_ovf_evt,
    input wire logic uart_tx_evt,
    input wire logic uart_rx_evt,
    input wire logic tmr2_ovf_evt,
    input wire logic tmr2_edge_evt,
    // vector hand-off to the core
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic irq_level,
    input wire logic irq_ack,
    input wire logic irq_reti,
    output logic in_service_hi,
    output logic in_service_lo
);
    // ======================================================
    // register state
    logic ext0_pending_flag_r;
    logic ext1_pending_flag_r;
    logic tmr0_overflow_flag_r;
    logic tmr1_overflow_flag_r;
    logic uart_tx_done_flag_r;
    logic uart_rx_done_flag_r;
    logic tmr2_overflow_flag_r;
    logic tmr2_edge_flag_r;
    logic [7:0] irq_enable_reg_r;
    logic [5:0] irq_level_reg_r;
    logic [7:0] sfr_rdata_r;
    logic irq_req_r;
    logic [15:0] irq_vector_r;
    logic irq_level_r;
    logic isr_hi_r;
    logic isr_lo_r;
    logic isr_hi_nxt;
    logic isr_lo_nxt;
    logic irq_req_nxt;
    logic [15:0] irq_vector_nxt;
    logic irq_level_nxt;
    logic [7:0] sfr_rdata_nxt;

    // ======================================================
    // address decode
    logic wr_tmr01;
    logic wr_serial;
    logic wr_enable;
    logic wr_level;
    logic wr_tmr2;
    assign wr_tmr01 = sfr_wr && (sfr_addr == ADDR_TMR01_CTRL);
    assign wr_serial = sfr_wr && (sfr_addr == ADDR_SERIAL_CTRL);
    assign wr_enable = sfr_wr && (sfr_addr == ADDR_IRQ_ENABLE);
    assign wr_level = sfr_wr && (sfr_addr == ADDR_IRQ_LEVEL);
    assign wr_tmr2 = sfr_wr && (sfr_addr == ADDR_TMR2_CTRL);

    // ======================================================
    // sticky request flags: event set wins over a software clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext0_pending_flag_r <= 1'b0;
        end else begin
            ext0_pending_flag_r <= ext0_evt |
                (wr_tmr01 ? sfr_wdata[BIT_EXT0_PEND] : ext0_pending_flag_r);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext1_pending_flag_r <= 1'b0;
        end else begin
            ext1_pending_flag_r <= ext1_evt |
                (wr_tmr01 ? sfr_wdata[BIT_EXT1_PEND] : ext1_pending_flag_r);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tmr0_overflow_flag_r <= 1'b0;
        end else begin
            tmr0_overflow_flag_r <= tmr0_ovf_evt |
                (wr_tmr01 ? sfr_wdata[BIT_TMR0_OVF] : tmr0_overflow_flag_r);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tmr1_overflow_flag_r <= 1'b0;
        end else begin
            tmr1_overflow_flag_r <= tmr1_ovf_evt |
                (wr_tmr01 ? sfr_wdata[BIT_TMR1_OVF] : tmr1_overflow_flag_r);
        end
    end

    // ======================================================
    // serial port done flags
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            uart_tx_done_flag_r <= 1'b0;
        end else begin
            uart_tx_done_flag_r <= uart_tx_evt |
                (wr_serial ? sfr_wdata[BIT_UART_TX] : uart_tx_done_flag_r);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            uart_rx_done_flag_r <= 1'b0;
        end else begin
            uart_rx_done_flag_r <= uart_rx_evt |
                (wr_serial ? sfr_wdata[BIT_UART_RX] : uart_rx_done_flag_r);
        end
    end

    // ======================================================
    // timer 2 overflow and edge flags
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tmr2_overflow_flag_r <= 1'b0;
        end else begin
            tmr2_overflow_flag_r <= tmr2_ovf_evt |
                (wr_tmr2 ? sfr_wdata[BIT_TMR2_OVF] : tmr2_overflow_flag_r);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tmr2_edge_flag_r <= 1'b0;
        end else begin
            tmr2_edge_flag_r <= tmr2_edge_evt |
                (wr_tmr2 ? sfr_wdata[BIT_TMR2_EDGE] : tmr2_edge_flag_r);
        end
    end

    // ======================================================
    // enable and level registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_enable_reg_r <= IRQ_ENABLE_RST;
        end else if (wr_enable) begin
            irq_enable_reg_r <= {sfr_wdata[7], 1'b0, sfr_wdata[5:0]};
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_level_reg_r <= IRQ_LEVEL_RST;
        end else if (wr_level) begin
            irq_level_reg_r <= sfr_wdata[5:0];
        end
    end

    // ======================================================
    // register read-back, one cycle after the read strobe
    always_comb begin
        sfr_rdata_nxt = sfr_rdata_r;
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_TMR01_CTRL: sfr_rdata_nxt = {tmr1_overflow_flag_r, 1'b0,
                    tmr0_overflow_flag_r, 1'b0, ext1_pending_flag_r, 1'b0,
                    ext0_pending_flag_r, 1'b0};
                ADDR_SERIAL_CTRL: sfr_rdata_nxt = {6'h00, uart_tx_done_flag_r,
                    uart_rx_done_flag_r};
                ADDR_TMR2_CTRL: sfr_rdata_nxt = {tmr2_overflow_flag_r,
                    tmr2_edge_flag_r, 6'h00};
                ADDR_IRQ_ENABLE: sfr_rdata_nxt = irq_enable_reg_r;
                ADDR_IRQ_LEVEL: sfr_rdata_nxt = IRQ_LEVEL_FIXED |
                    {2'b00, irq_level_reg_r};
                default: sfr_rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata_r <= 8'h00;
        end else begin
            sfr_rdata_r <= sfr_rdata_nxt;
        end
    end

    // ======================================================
    // source requests and gating
    logic [NSRC-1:0] src_flag;
    logic [NSRC-1:0] src_pend;
    always_comb begin
        src_flag[SRC_EXT0] = ext0_pending_flag_r;
        src_flag[SRC_TMR0] = tmr0_overflow_flag_r;
        src_flag[SRC_EXT1] = ext1_pending_flag_r;
        src_flag[SRC_TMR1] = tmr1_overflow_flag_r;
        src_flag[SRC_UART] = uart_tx_done_flag_r | uart_rx_done_flag_r;
        src_flag[SRC_TMR2] = tmr2_overflow_flag_r | tmr2_edge_flag_r;
    end
    // a source needs its own enable and the global gate
    assign src_pend = src_flag & irq_enable_reg_r[NSRC-1:0] &
        {NSRC{irq_enable_reg_r[BIT_GLOBAL_GATE]}};

    // ======================================================
    // per-level pickers
    tvi_req_if hi_bus ();
    tvi_req_if lo_bus ();
    assign hi_bus.req = src_pend & irq_level_reg_r;
    assign lo_bus.req = src_pend & ~irq_level_reg_r;

    tvi_picker u_pick_hi (
        .bus(hi_bus)
    );
    tvi_picker u_pick_lo (
        .bus(lo_bus)
    );

    // ======================================================
    // in-service tracking
    // an ack counts only while a request is shown
    // return clears the higher level in service first
    logic take_vec;
    assign take_vec = irq_ack && irq_req_r;
    always_comb begin
        isr_hi_nxt = isr_hi_r;
        isr_lo_nxt = isr_lo_r;
        if (take_vec) begin
            if (irq_level_r) begin
                isr_hi_nxt = 1'b1;
            end else begin
                isr_lo_nxt = 1'b1;
            end
        end else if (irq_reti) begin
            if (isr_hi_r) begin
                isr_hi_nxt = 1'b0;
            end else begin
                isr_lo_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            isr_hi_r <= 1'b0;
        end else begin
            isr_hi_r <= isr_hi_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            isr_lo_r <= 1'b0;
        end else begin
            isr_lo_r <= isr_lo_nxt;
        end
    end

    // ======================================================
    // vector per picker: base plus eight bytes per source
    logic [15:0] hi_vec;
    logic [15:0] lo_vec;
    assign hi_vec = VEC_BASE + (16'(hi_bus.idx) << VEC_SHIFT);
    assign lo_vec = VEC_BASE + (16'(lo_bus.idx) << VEC_SHIFT);

    // ======================================================
    // arbitration and vector generation
    always_comb begin
        irq_req_nxt = 1'b0;
        irq_level_nxt = 1'b0;
        irq_vector_nxt = irq_vector_r;
        if (isr_hi_nxt) begin
            irq_req_nxt = 1'b0;
        end else if (hi_bus.valid) begin
            irq_req_nxt = 1'b1;
            irq_level_nxt = 1'b1;
            irq_vector_nxt = hi_vec;
        end else if (lo_bus.valid && !isr_lo_nxt) begin
            irq_req_nxt = 1'b1;
            irq_level_nxt = 1'b0;
            irq_vector_nxt = lo_vec;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_req_r <= 1'b0;
        end else begin
            irq_req_r <= irq_req_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_level_r <= 1'b0;
        end else begin
            irq_level_r <= irq_level_nxt;
        end
    end

    // vector holds its last value while no request is shown
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_vector_r <= VEC_BASE;
        end else begin
            irq_vector_r <= irq_vector_nxt;
        end
    end

    // ======================================================
    // outputs
    assign sfr_rdata = sfr_rdata_r;
    assign irq_req = irq_req_r;
    assign irq_vector = irq_vector_r;
    assign irq_level = irq_level_r;
    assign in_service_hi = isr_hi_r;
    assign in_service_lo = isr_lo_r;
endmodule // tvi_top

// [verification/tb.sv]
// self-checking bench for the two-level vectored interrupt unit
`timescale 1ns/100ps
module tb;
    import tvi_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, ev = 8'h00, sfr_rdata;
    logic ack_en = 1'b0, reti_go = 1'b0, irq_req, irq_level, irq_ack, irq_reti, ish, isl;
    logic [3:0] slow = 4'h0;
    logic [15:0] irq_vector;
    logic [7:0] clr_a [0:5] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'h98, 8'hC8};
    logic [7:0] clr_d [0:5] = '{8'hA8, 8'h88, 8'h80, 8'h00, 8'h00, 8'h00};
    logic [15:0] vec_x [0:5] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
    int bad_count = 0, num_checks = 0;
    always #4 ref_clk = ~ref_clk;
    tvi_top tvi_top_i (.ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .ext0_evt(ev[0]), .tmr0_ovf_evt(ev[1]), .ext1_evt(ev[2]), .tmr1_ovf_evt(ev[3]),
        .uart_tx_evt(ev[4]), .uart_rx_evt(ev[5]), .tmr2_ovf_evt(ev[6]),
        .tmr2_edge_evt(ev[7]), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_level(irq_level), .irq_ack(irq_ack), .irq_reti(irq_reti),
        .in_service_hi(ish), .in_service_lo(isl));
    tvi_cpu_model cpu_i (.ref_clk(ref_clk), .irq_req(irq_req), .irq_vector(irq_vector),
        .ack_en(ack_en), .slow(slow), .reti_go(reti_go), .irq_ack(irq_ack),
        .irq_reti(irq_reti));
    // ======================================================
    // tasks
    task results;
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge ref_clk) sfr_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk) {sfr_addr, sfr_rd} = {a, 1'b1};
        @(negedge ref_clk) sfr_rd = 1'b0;
        cmp({8'h00, sfr_rdata}, {8'h00, exp});
    endtask
    task pulse(input logic [7:0] m);
        @(negedge ref_clk) ev = m;
        @(negedge ref_clk) ev = 8'h00;
    endtask
    task ret;
        @(negedge ref_clk) reti_go = 1'b1;
        @(negedge ref_clk) reti_go = 1'b0;
    endtask
    // wait for the n-th accepted vector, then for the accepting edge
    task take(input int n, input logic [15:0] exp);
        for (int k = 0; k < 60 && cpu_i.n_seen < n; k++) @(negedge ref_clk);
        @(negedge ref_clk);
        cmp(cpu_i.seen[n - 1], exp);
    endtask
    // ======================================================
    // tests
    initial begin
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        rd(ADDR_IRQ_ENABLE, 8'h00);
        rd(ADDR_IRQ_LEVEL, 8'h80);
        wr(ADDR_IRQ_ENABLE, 8'hFF);
        rd(ADDR_IRQ_ENABLE, 8'hBF);
        wr(8'h90, 8'hFF);
        rd(8'h90, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h3F);
        ack_en = 1'b1;
        pulse(8'hFF);
        repeat (20) @(negedge ref_clk);
        cmp(16'(cpu_i.n_seen), 16'h0000);
        rd(ADDR_TMR01_CTRL, 8'hAA);
        rd(ADDR_SERIAL_CTRL, 8'h03);
        rd(ADDR_TMR2_CTRL, 8'hC0);
        wr(ADDR_IRQ_ENABLE, 8'h80);
        repeat (10) @(negedge ref_clk);
        cmp(16'(cpu_i.n_seen), 16'h0000);
        slow = 4'h3;
        wr(ADDR_IRQ_ENABLE, 8'hBF);
        for (int i = 0; i < 6; i++) begin
            take(i + 1, vec_x[i]);
            cmp({14'h0000, ish, isl}, 16'h0001);
            wr(clr_a[i], clr_d[i]);
            ret();
        end
        slow = 4'h0;
        wr(ADDR_IRQ_LEVEL, 8'h20);
        rd(ADDR_IRQ_LEVEL, 8'hA0);
        pulse(8'hC1);
        take(7, 16'h002B);
        cmp({14'h0000, ish, isl}, 16'h0002);
        repeat (10) @(negedge ref_clk);
        cmp(16'(cpu_i.n_seen), 16'h0007);
        wr(ADDR_TMR2_CTRL, 8'h00);
        ret();
        take(8, 16'h0003);
        pulse(8'h40);
        take(9, 16'h002B);
        cmp({14'h0000, ish, isl}, 16'h0003);
        wr(ADDR_TMR2_CTRL, 8'h00);
        ret();
        wr(ADDR_TMR01_CTRL, 8'h00);
        ret();
        pulse(8'h20);
        take(10, 16'h0023);
        wr(ADDR_SERIAL_CTRL, 8'h00);
        ret();
        pulse(8'h80);
        take(11, 16'h002B);
        wr(ADDR_TMR2_CTRL, 8'h00);
        ret();
        repeat (2) @(negedge ref_clk);
        cmp({14'h0000, ish, isl}, 16'h0000);
        results();
    end
    initial begin
        #100000;
        bad_count++;
        results();
    end
endmodule // tb
bind tvi_top tvi_checker tvi_checker_i (.ref_clk(ref_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .irq_ack(irq_ack), .irq_reti(irq_reti),
    .in_service_hi(in_service_hi), .in_service_lo(in_service_lo));

// [verification/tvi_checker.sv]
// port-level assertions for the two-level vectored interrupt unit
`timescale 1ns/100ps
module tvi_checker
    import tvi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic irq_level,
    input wire logic irq_ack,
    input wire logic irq_reti,
    input wire logic in_service_hi,
    input wire logic in_service_lo
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [7:0] en_r;
    logic [7:0] lv_r;
    // ======================================================
    // mirrors of the enable and level registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            en_r <= 8'h00;
            lv_r <= 8'h00;
        end else if (sfr_wr && sfr_addr == ADDR_IRQ_ENABLE) begin
            en_r <= sfr_wdata & 8'hBF;
        end else if (sfr_wr && sfr_addr == ADDR_IRQ_LEVEL) begin
            lv_r <= sfr_wdata & 8'h3F;
        end
    end
    // ======================================================
    // assertions
    property p_vec; irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector[15:3] <= 13'h0005; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_en; irq_req |-> $past(en_r[7]) && ($past(en_r) >> irq_vector[5:3]) & 8'h01; endproperty
    a_en: assert property (p_en) else $error("request not enabled");
    property p_lvl; irq_req |-> irq_level == ((($past(lv_r) >> irq_vector[5:3]) & 8'h01) != 8'h00); endproperty
    a_lvl: assert property (p_lvl) else $error("wrong level");
    property p_hi_blk; in_service_hi |-> !irq_req; endproperty
    a_hi_blk: assert property (p_hi_blk) else $error("request during high service");
    property p_lo_pre; in_service_lo && irq_req |-> irq_level; endproperty
    a_lo_pre: assert property (p_lo_pre) else $error("low request in low service");
    property p_acc_hi; irq_ack && irq_req && irq_level |=> in_service_hi; endproperty
    a_acc_hi: assert property (p_acc_hi) else $error("high accept lost");
    property p_acc_lo; irq_ack && irq_req && !irq_level |=> in_service_lo; endproperty
    a_acc_lo: assert property (p_acc_lo) else $error("low accept lost");
    property p_ret; irq_reti && !(irq_ack && irq_req) && in_service_hi |=> !in_service_hi; endproperty
    a_ret: assert property (p_ret) else $error("return kept high");
    property p_ip7; sfr_rd && sfr_addr == ADDR_IRQ_LEVEL |=> sfr_rdata == ($past(lv_r) | 8'h80); endproperty
    a_ip7: assert property (p_ip7) else $error("bad level read");
    property p_ie_rd; sfr_rd && sfr_addr == ADDR_IRQ_ENABLE |=> sfr_rdata == $past(en_r); endproperty
    a_ie_rd: assert property (p_ie_rd) else $error("bad enable read");
endmodule // tvi_checker

// [verification/tvi_cpu_model.sv]
// core model: takes presented vectors, returns on command
`timescale 1ns/100ps
module tvi_cpu_model (
    input wire logic ref_clk,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic ack_en,
    input wire logic [3:0] slow,
    input wire logic reti_go,
    output logic irq_ack,
    output logic irq_reti
);
    logic [15:0] seen [0:15];
    int n_seen = 0;
    int w = 0;
    initial begin
        irq_ack = 1'b0;
    end
    // return pulse comes from the bench, already on the falling edge
    assign irq_reti = reti_go;
    // one-cycle ack after slow cycles of waiting, never back to back;
    // falling edge, so the logged vector is the one the unit takes
    always @(negedge ref_clk) begin
        if (irq_ack) begin
            irq_ack <= 1'b0;
        end else if (ack_en && irq_req === 1'b1 && w >= int'(slow)) begin
            irq_ack <= 1'b1;
            seen[n_seen[3:0]] <= irq_vector;
            n_seen <= n_seen + 1;
            w <= 0;
        end else if (irq_req === 1'b1) begin
            w <= w + 1;
        end
    end
endmodule // tvi_cpu_model
